// file: rtl/hrpc_defs.svh
`ifndef HRPC_DEFS_SVH
`define HRPC_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HRPC_OFF_COUNT 12'h000
`define HRPC_OFF_MATCH_A 12'h004
`define HRPC_OFF_MATCH_B 12'h008
`define HRPC_OFF_LOAD 12'h00c
`define HRPC_OFF_CTRL 12'h010
`define HRPC_OFF_MASK 12'h014
`define HRPC_OFF_RAW 12'h018
`define HRPC_OFF_MIS 12'h01c
`define HRPC_OFF_CLR 12'h020
`define HRPC_OFF_TRIM 12'h024
`define HRPC_OFF_STATE 12'h028
`define HRPC_OFF_DATA 12'h030
`define HRPC_OFF_DATA_END 12'h12c
// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define HRPC_CTL_COUNTER_EN 0
`define HRPC_CTL_SLEEP_REQ 1
`define HRPC_CTL_MATCH_WEN 3
`define HRPC_CTL_PIN_WEN 4
`define HRPC_CTL_LOWBATT_EN 5
`define HRPC_CTL_ABORT_LB 7
`define HRPC_CTL_KEEP_IO 8
`define HRPC_CTL_MASK 32'h000001bb
// ----------------------------------------------------------------------
// Event bits
// ----------------------------------------------------------------------
`define HRPC_EV_MATCH_A 0
`define HRPC_EV_MATCH_B 1
`define HRPC_EV_LOWBATT 2
`define HRPC_EV_PIN 3
// ----------------------------------------------------------------------
// Timing and reset values, bus response codes
// ----------------------------------------------------------------------
`define HRPC_TRIM_RST 16'h7fff
`define HRPC_PREDIV_NOM 16'h7fff
`define HRPC_TRIM_PERIOD 6'h3f
`define HRPC_XTAL_DIV 7'h7f
`define HRPC_RESP_OKAY 2'h0
`define HRPC_RESP_SLVERR 2'h2
`endif

// file: rtl/hrpc_pkg.sv
package hrpc_pkg;
  typedef enum logic [1:0] {
    HRPC_RUN,
    HRPC_WAIT_FLASH,
    HRPC_HIBERNATED,
    HRPC_WAIT_SUPPLY
  } hrpc_state_e;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } hrpc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hrpc_axi_rsp_s;

  typedef struct packed {
    hrpc_state_e st;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [3:0] mask;
    logic [3:0] raw;
    logic [15:0] trim;
    logic [31:0] count;
    logic [31:0] match_a;
    logic [31:0] match_b;
    logic [15:0] prediv;
    logic [5:0] sec_cnt;
    logic [6:0] xdiv;
    logic wake_pin_d;
    logic regulator_enable_n;
    logic io_isolate;
    logic por_req;
  } hrpc_state_s;
endpackage : hrpc_pkg

// file: rtl/hrpc_top.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "hrpc_defs.svh"
module hrpc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire hrpc_pkg::hrpc_axi_req_s axi_req,
  output hrpc_pkg::hrpc_axi_rsp_s axi_rsp,
  // Timebase: one tick per 32.768 kHz period or per crystal cycle
  input wire logic tick_in,
  input wire logic tick_is_xtal,
  // Power and pins
  input wire logic wake_pin_n,
  input wire logic backup_low,
  input wire logic main_supply_good,
  input wire logic flash_write_busy,
  output logic regulator_enable_n,
  output logic io_isolate,
  output logic por_req,
  output logic hibernated,
  // Interrupt request
  output logic irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  hrpc_pkg::hrpc_state_s s_r;
  hrpc_pkg::hrpc_state_s s_nxt;
  logic [31:0] mem_r [0:63];
  logic mem_we;
  logic [5:0] mem_widx;
  logic [31:0] mem_wval;

  // Byte-lane merge of write data into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  logic do_wr;
  logic do_rd;
  logic sec_tick;
  logic tick32;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic wake_cond;
  logic in_hib;
  logic [11:0] wa;
  logic [11:0] ra;
  logic [31:0] wv;
  // Write strobes and data-window offsets are worked out once at the top
  // of the process, so no variable is born inside a nested block.
  logic [3:0] wr_strb;
  logic [11:0] wr_off;
  logic [11:0] rd_off;

  // Bus timing in short: a write is executed at the edge where address
  // and data are both present, held or live, and the response is raised
  // at that same edge. A read is answered at the edge where it is taken.
  // The answer then stands until the master takes it. Readies drop while
  // an answer is pending, so a second request of the same kind waits.

  // All state moves in one process so every flag sees set and clear at
  // the same place; set is applied last so a simultaneous event wins.
  always_comb begin
    s_nxt = s_r;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    mem_we = 1'b0;
    mem_widx = 6'h00;
    mem_wval = 32'h00000000;
    in_hib = (s_r.st == hrpc_pkg::HRPC_HIBERNATED) ||
             (s_r.st == hrpc_pkg::HRPC_WAIT_SUPPLY);
    wa = s_r.aw_held ? s_r.aw_addr : axi_req.awaddr;
    wv = s_r.w_held ? s_r.w_data : axi_req.wdata;
    do_wr = (s_r.aw_held || axi_req.awvalid) &&
            (s_r.w_held || axi_req.wvalid) && !s_r.bvalid;
    do_rd = axi_req.arvalid && !s_r.rvalid;
    ra = axi_req.araddr;
    wr_strb = s_r.w_held ? s_r.w_strb : axi_req.wstrb;
    wr_off = wa - `HRPC_OFF_DATA;
    rd_off = ra - `HRPC_OFF_DATA;

    // Crystal ticks are divided by 128 to get the 32.768 kHz rate.
    tick32 = 1'b0;
    if (tick_in) begin
      if (tick_is_xtal) begin
        s_nxt.xdiv = s_r.xdiv - 7'h01;
        tick32 = (s_r.xdiv == 7'h00);
      end else begin
        tick32 = 1'b1;
      end
    end

    // Predivider counts down; the 64th second uses the trim value.
    sec_tick = 1'b0;
    if (tick32 && s_r.ctrl[`HRPC_CTL_COUNTER_EN]) begin
      if (s_r.prediv == 16'h0000) begin
        sec_tick = 1'b1;
        s_nxt.sec_cnt = s_r.sec_cnt + 6'h01;
        s_nxt.count = s_r.count + 32'h00000001;
        // Larger trim gives a longer second, hence a slower clock.
        if (s_r.sec_cnt == `HRPC_TRIM_PERIOD) begin
          s_nxt.prediv = s_r.trim;
        end else begin
          s_nxt.prediv = `HRPC_PREDIV_NOM;
        end
      end else begin
        s_nxt.prediv = s_r.prediv - 16'h0001;
      end
    end

    // Event sources.
    if (s_r.count == s_r.match_a && sec_tick) begin
      ev_set[`HRPC_EV_MATCH_A] = 1'b1;
    end
    if (s_r.count == s_r.match_b && sec_tick) begin
      ev_set[`HRPC_EV_MATCH_B] = 1'b1;
    end
    if (s_r.ctrl[`HRPC_CTL_LOWBATT_EN] && backup_low && !in_hib) begin
      ev_set[`HRPC_EV_LOWBATT] = 1'b1;
    end
    s_nxt.wake_pin_d = !wake_pin_n;
    if (!wake_pin_n && !s_r.wake_pin_d) begin
      ev_set[`HRPC_EV_PIN] = 1'b1;
    end

    // Write address and data are taken in either order.
    // A channel is only captured while its ready is high; taking it
    // while a response is pending would repeat the write later.
    if (axi_req.awvalid && !s_r.aw_held && !s_r.bvalid && !do_wr) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_r.w_held && !s_r.bvalid && !do_wr) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
    end
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Write decode. Read-only offsets accept the write and ignore it, so
    // software sees OKAY; only an unmapped offset answers with an error.
    if (do_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `HRPC_RESP_OKAY;
      case (wa)
        `HRPC_OFF_COUNT, `HRPC_OFF_RAW, `HRPC_OFF_MIS, `HRPC_OFF_STATE: begin
        end
        `HRPC_OFF_LOAD: begin
          // A load overrides any increment of the same cycle.
          s_nxt.count = merge(s_r.count, wv, wr_strb);
        end
        `HRPC_OFF_MATCH_A: begin
          s_nxt.match_a = merge(s_r.match_a, wv, wr_strb);
        end
        `HRPC_OFF_MATCH_B: begin
          s_nxt.match_b = merge(s_r.match_b, wv, wr_strb);
        end
        `HRPC_OFF_CTRL: begin
          // Unused control bits are kept at zero so they read back 0.
          s_nxt.ctrl = merge(s_r.ctrl, wv, wr_strb) & `HRPC_CTL_MASK;
        end
        `HRPC_OFF_MASK: begin
          s_nxt.mask = 4'(merge({28'h0000000, s_r.mask}, wv, wr_strb));
        end
        `HRPC_OFF_CLR: begin
          // All event bits sit in byte lane 0.
          ev_clr = wr_strb[0] ? wv[3:0] : 4'h0;
        end
        `HRPC_OFF_TRIM: begin
          s_nxt.trim = 16'(merge({16'h0000, s_r.trim}, wv, wr_strb));
        end
        default: begin
          // Retained words: one aligned word per index.
          if (wa >= `HRPC_OFF_DATA && wa <= `HRPC_OFF_DATA_END &&
              wa[1:0] == 2'b00) begin
            mem_we = 1'b1;
            mem_widx = wr_off[7:2];
            mem_wval = merge(mem_r[wr_off[7:2]], wv, wr_strb);
          end else begin
            s_nxt.bresp = `HRPC_RESP_SLVERR;
          end
        end
      endcase
    end

    // Sticky flags: clear first, then set so a coincident event stays.
    s_nxt.raw = (s_r.raw & ~ev_clr) | ev_set;

    // Read channel. The word is latched when the read is taken, so a
    // master that is slow with rready still sees the value of that edge,
    // even while the counter goes on moving underneath.
    if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `HRPC_RESP_OKAY;
      case (ra)
        `HRPC_OFF_COUNT: s_nxt.rdata = s_r.count;
        `HRPC_OFF_MATCH_A: s_nxt.rdata = s_r.match_a;
        `HRPC_OFF_MATCH_B: s_nxt.rdata = s_r.match_b;
        `HRPC_OFF_LOAD, `HRPC_OFF_CLR: s_nxt.rdata = 32'h00000000;
        `HRPC_OFF_CTRL: s_nxt.rdata = s_r.ctrl;
        `HRPC_OFF_MASK: s_nxt.rdata = {28'h0000000, s_r.mask};
        `HRPC_OFF_RAW: s_nxt.rdata = {28'h0000000, s_r.raw};
        `HRPC_OFF_MIS: begin
          s_nxt.rdata = {28'h0000000, s_r.raw & s_r.mask};
        end
        `HRPC_OFF_TRIM: s_nxt.rdata = {16'h0000, s_r.trim};
        `HRPC_OFF_STATE: s_nxt.rdata = {30'h00000000, s_r.st};
        default: begin
          // Retained words read back; anything else is an error.
          if (ra >= `HRPC_OFF_DATA && ra <= `HRPC_OFF_DATA_END &&
              ra[1:0] == 2'b00) begin
            s_nxt.rdata = mem_r[rd_off[7:2]];
          end else begin
            s_nxt.rdata = 32'h00000000;
            s_nxt.rresp = `HRPC_RESP_SLVERR;
          end
        end
      endcase
    end

    // Wake sources gated by their enables.
    wake_cond = (s_r.ctrl[`HRPC_CTL_PIN_WEN] && !wake_pin_n) ||
                (s_r.ctrl[`HRPC_CTL_MATCH_WEN] &&
                 (ev_set[`HRPC_EV_MATCH_A] || ev_set[`HRPC_EV_MATCH_B]));

    // Power sequencer. Entry waits for the flash interlock; exit waits
    // for the main supply, so the restart pulse never meets a sagging
    // rail. A limitation: a wake enable is not checked at the request,
    // so software that arms none leaves the chip asleep until reset.
    s_nxt.por_req = 1'b0;
    case (s_r.st)
      hrpc_pkg::HRPC_RUN: begin
        if (s_r.ctrl[`HRPC_CTL_SLEEP_REQ]) begin
          // Software must have armed a wake source beforehand.
          if (s_r.ctrl[`HRPC_CTL_ABORT_LB] &&
              s_r.raw[`HRPC_EV_LOWBATT]) begin
            s_nxt.ctrl[`HRPC_CTL_SLEEP_REQ] = 1'b0;
          end else begin
            s_nxt.st = hrpc_pkg::HRPC_WAIT_FLASH;
          end
        end
      end
      hrpc_pkg::HRPC_WAIT_FLASH: begin
        if (!flash_write_busy) begin
          s_nxt.st = hrpc_pkg::HRPC_HIBERNATED;
          s_nxt.ctrl[`HRPC_CTL_SLEEP_REQ] = 1'b0;
          if (s_r.ctrl[`HRPC_CTL_KEEP_IO]) begin
            s_nxt.io_isolate = 1'b1;
          end else begin
            s_nxt.regulator_enable_n = 1'b0;
          end
        end
      end
      hrpc_pkg::HRPC_HIBERNATED: begin
        if (wake_cond) begin
          s_nxt.st = hrpc_pkg::HRPC_WAIT_SUPPLY;
          s_nxt.regulator_enable_n = 1'b1;
        end
      end
      hrpc_pkg::HRPC_WAIT_SUPPLY: begin
        if (main_supply_good) begin
          s_nxt.st = hrpc_pkg::HRPC_RUN;
          s_nxt.io_isolate = 1'b0;
          s_nxt.por_req = 1'b1;
        end
      end
      default: s_nxt.st = hrpc_pkg::HRPC_RUN;
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // The power-on pulse does not reset this block: flags and memory keep.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= hrpc_pkg::HRPC_RUN;
      s_r.trim <= `HRPC_TRIM_RST;
      s_r.prediv <= `HRPC_PREDIV_NOM;
      s_r.xdiv <= `HRPC_XTAL_DIV;
      s_r.regulator_enable_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Retained words have no reset; their content after cold start is
  // undefined, as for any battery memory.
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem_r[mem_widx] <= mem_wval;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Handshake readies are combinational; data comes from flops.
  always_comb begin
    axi_rsp.awready = !s_r.aw_held && !s_r.bvalid;
    axi_rsp.wready = !s_r.w_held && !s_r.bvalid;
    axi_rsp.bvalid = s_r.bvalid;
    axi_rsp.bresp = s_r.bresp;
    axi_rsp.arready = !s_r.rvalid;
    axi_rsp.rvalid = s_r.rvalid;
    axi_rsp.rdata = s_r.rdata;
    axi_rsp.rresp = s_r.rresp;
  end

  assign regulator_enable_n = s_r.regulator_enable_n;
  assign io_isolate = s_r.io_isolate;
  assign por_req = s_r.por_req;
  assign hibernated = (s_r.st == hrpc_pkg::HRPC_HIBERNATED);
  assign irq = |(s_r.raw & s_r.mask);

endmodule : hrpc_top

// file: test/hrpc_checker.sv
`timescale 1ns/10ps
// ---
// Port checker
// ---
module hrpc_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire hrpc_pkg::hrpc_axi_req_s axi_req,
  input wire hrpc_pkg::hrpc_axi_rsp_s axi_rsp,
  // Power pins
  input wire logic flash_write_busy,
  input wire logic main_supply_good,
  input wire logic regulator_enable_n,
  input wire logic io_isolate,
  input wire logic por_req,
  input wire logic hibernated
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus handshakes that open an answer.
  sequence s_wr;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  // A stalled master must still see the same read word.
  property p_wr; s_wr |=> axi_rsp.bvalid; endproperty
  property p_rd; s_rd |=> axi_rsp.rvalid; endproperty
  property p_rhold;
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  // Power sequencing seen at the pins.
  property p_flash; !hibernated && flash_write_busy |=> !hibernated; endproperty
  property p_enter; $rose(hibernated) |-> !regulator_enable_n || io_isolate;
  endproperty
  property p_keep; io_isolate |-> regulator_enable_n; endproperty
  property p_leave; $fell(hibernated) |-> regulator_enable_n; endproperty
  property p_supply; por_req |-> $past(main_supply_good) && !hibernated;
  endproperty
  property p_por; por_req |=> !por_req && !hibernated; endproperty
  a_wr: assert property (p_wr) else $error("write unanswered");
  a_rd: assert property (p_rd) else $error("read unanswered");
  a_rhold: assert property (p_rhold) else $error("read data moved");
  a_flash: assert property (p_flash)
    else $error("slept in flash write");
  a_enter: assert property (p_enter) else $error("regulator left on");
  a_keep: assert property (p_keep)
    else $error("regulator cut in keep");
  a_leave: assert property (p_leave) else $error("regulator not back");
  a_supply: assert property (p_supply) else $error("early exit");
  a_por: assert property (p_por) else $error("bad restart pulse");
endmodule : hrpc_checker
bind hrpc_top hrpc_checker chk_u (.aclk, .aresetn, .axi_req, .axi_rsp,
  .flash_write_busy, .main_supply_good, .regulator_enable_n, .io_isolate,
  .por_req, .hibernated);

// file: test/hrpc_partner.sv
`timescale 1ns/10ps
// ---
// Regulator and wake source model
// ---
module hrpc_partner (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Regulator
  input wire logic regulator_enable_n,
  input wire logic [7:0] ramp_cycles,
  output logic main_supply_good,
  // Wake source
  input wire logic wake_cmd,
  output logic wake_pin_n
);
  logic [7:0] up_r;
  // Power drops at once but ramps back slowly, so a slow supply can hold
  // off the exit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_r <= 8'hff;
    end else if (!regulator_enable_n) begin
      up_r <= 8'h00;
    end else if (up_r != 8'hff) begin
      up_r <= up_r + 8'h01;
    end
  end
  assign main_supply_good = (up_r >= ramp_cycles);
  // The pin idles high on its pull-up.
  assign wake_pin_n = !wake_cmd;
endmodule : hrpc_partner

// file: test/hrpc_top_tb.sv
`timescale 1ns/10ps
`include "hrpc_defs.svh"
// ---
// Bench
// ---
module hrpc_top_tb;
  logic aclk, aresetn, tick_in, wake_cmd, backup_low, flash_write_busy;
  logic main_supply_good, wake_pin_n, regulator_enable_n, io_isolate;
  logic por_req, hibernated, irq;
  logic [7:0] ramp_cycles;
  logic [1:0] rs;
  logic [31:0] seed, rd, n0, mem [64];
  int num_errors, compares, cyc;
  hrpc_pkg::hrpc_axi_req_s axi_req;
  hrpc_pkg::hrpc_axi_rsp_s axi_rsp;
  hrpc_top dut_u (.aclk, .aresetn, .axi_req, .axi_rsp, .tick_in,
    .tick_is_xtal(1'b0), .wake_pin_n, .backup_low, .main_supply_good,
    .flash_write_busy, .regulator_enable_n, .io_isolate, .por_req,
    .hibernated, .irq);
  hrpc_partner prt_u (.aclk, .aresetn, .regulator_enable_n, .ramp_cycles,
    .main_supply_good, .wake_cmd, .wake_pin_n);
  // Clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = !aclk;
  end
  // A hung wait ends the run as a failure.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      print_verdict();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Counter value after t ticks at the nominal divide of 0x7fff plus one.
  function automatic logic [31:0] exp_count(logic [31:0] s, int t);
    return s + 32'(t / 32768);
  endfunction : exp_count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chk1
  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Address and data go out together; each drops when taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : wr
  // Ready is sometimes late, so the slave must hold its answer.
  task automatic rd_reg(input logic [11:0] a);
    logic [31:0] r;
    r = xs();
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= r[0];
    do begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid && !axi_req.rready) axi_req.rready <= 1'b1;
    end while (!(axi_rsp.rvalid && axi_req.rready));
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : rd_reg
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(rd, e);
  endtask : rc
  task automatic ticks(input int n);
    @(posedge aclk);
    tick_in <= 1'b1;
    repeat (n) @(posedge aclk);
    tick_in <= 1'b0;
  endtask : ticks
  // Main sequence.
  initial begin
    seed = 32'h44;
    axi_req = '0;
    axi_req.wstrb = 4'hf;
    {aresetn, tick_in, wake_cmd, backup_low, flash_write_busy} = 5'h0;
    ramp_cycles = 8'h04;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h024, 32'h7fff);
    rc(12'h018, 32'h0);
    rc(12'h000, 32'h0);
    rc(12'h02c, 32'h0);
    chk({30'h0, rs}, {30'h0, `HRPC_RESP_SLVERR});
    n0 = xs();
    wr(12'h024, n0);
    rc(12'h024, {16'h0, n0[15:0]});
    wr(12'h024, 32'h7fff);
    for (int i = 0; i < 64; i++) begin
      mem[i] = xs();
      wr(12'(12'h030 + 4 * i), mem[i]);
    end
    for (int i = 0; i < 64; i++) begin
      rc(12'(12'h030 + 4 * i), mem[i]);
    end
    // Load, hold while disabled, then one full second.
    n0 = xs();
    wr(12'h00c, n0);
    ticks(100);
    rc(12'h000, n0);
    rc(12'h00c, 32'h0);
    wr(12'h004, n0);
    wr(12'h008, n0);
    wr(12'h010, 32'h1);
    ticks(32767);
    rc(12'h000, exp_count(n0, 32767));
    rc(12'h018, 32'h0);
    ticks(1);
    rc(12'h000, exp_count(n0, 32768));
    rc(12'h018, 32'h3);
    wr(12'h014, 32'h1);
    rc(12'h01c, 32'h1);
    chk1(irq, 1'b1);
    wr(12'h014, 32'h2);
    rc(12'h01c, 32'h2);
    chk1(irq, 1'b1);
    wr(12'h014, 32'h0);
    rc(12'h01c, 32'h0);
    chk1(irq, 1'b0);
    wr(12'h020, 32'h0);
    rc(12'h018, 32'h3);
    wr(12'h020, 32'h1);
    rc(12'h018, 32'h2);
    wr(12'h020, 32'h2);
    rc(12'h018, 32'h0);
    // Low battery, then a refused request.
    backup_low <= 1'b1;
    wr(12'h010, 32'h0);
    rc(12'h018, 32'h0);
    wr(12'h010, 32'h20);
    rc(12'h018, 32'h4);
    backup_low <= 1'b0;
    wr(12'h010, 32'hb2);
    repeat (5) @(posedge aclk);
    rc(12'h028, 32'h0);
    chk1(regulator_enable_n, 1'b1);
    rc(12'h010, 32'hb0);
    wr(12'h020, 32'h4);
    rc(12'h018, 32'h0);
    // Sleep held off by flash; pin wake disabled, match wake armed.
    wr(12'h004, n0 + 32'h1);
    flash_write_busy <= 1'b1;
    wr(12'h010, 32'h29);
    wr(12'h010, 32'h2b);
    rc(12'h028, 32'h1);
    chk1(regulator_enable_n, 1'b1);
    flash_write_busy <= 1'b0;
    while (hibernated !== 1'b1) @(posedge aclk);
    chk1(regulator_enable_n, 1'b0);
    backup_low <= 1'b1;
    wake_cmd <= 1'b1;
    repeat (20) @(posedge aclk);
    chk1(hibernated, 1'b1);
    rd_reg(12'h018);
    chk1(rd[2], 1'b0);
    // One more second ends while the count holds the match value and wakes the chip.
    ticks(32768);
    repeat (2) @(posedge aclk);
    chk1(hibernated, 1'b0);
    chk1(regulator_enable_n, 1'b1);
    rd_reg(12'h018);
    chk1(rd[0], 1'b1);
    {wake_cmd, backup_low, aresetn} <= 3'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Pin wake with a slow supply.
    ramp_cycles <= 8'h28;
    n0 = xs();
    wr(12'h030, n0);
    wr(12'h010, 32'h10);
    wr(12'h010, 32'h12);
    while (hibernated !== 1'b1) @(posedge aclk);
    wake_cmd <= 1'b1;
    while (regulator_enable_n !== 1'b1) @(posedge aclk);
    chk1(main_supply_good, 1'b0);
    chk1(por_req, 1'b0);
    while (por_req !== 1'b1) @(posedge aclk);
    chk1(main_supply_good, 1'b1);
    wake_cmd <= 1'b0;
    rc(12'h018, 32'h8);
    rc(12'h030, n0);
    // Keep-supply mode.
    wr(12'h020, 32'h8);
    wr(12'h010, 32'h112);
    while (hibernated !== 1'b1) @(posedge aclk);
    chk1(io_isolate, 1'b1);
    chk1(regulator_enable_n, 1'b1);
    wake_cmd <= 1'b1;
    while (por_req !== 1'b1) @(posedge aclk);
    wr(12'h014, 32'h8);
    rc(12'h01c, 32'h8);
    chk1(irq, 1'b1);
    print_verdict();
  end
endmodule : hrpc_top_tb
